// ===== inc/ccr_defs.svh
// constants for the core clock ratio control block
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

// ****************************************
// widths
// ****************************************
`define CCR_MULT_W        7
`define CCR_DIV_W         5
`define CCR_CNT_W         4
`define CCR_NUM_W         8
`define CCR_DEN_W         6

// ****************************************
// strap encodings and their core:input ratios
// ****************************************
`define CCR_STRAP_DEFAULT 2'h0
`define CCR_STRAP_SEL1    2'h1
`define CCR_STRAP_SEL2    2'h2
`define CCR_RATIO_DEFAULT 7'h10
`define CCR_RATIO_SEL1    7'h20
`define CCR_RATIO_SEL2    7'h08
`define CCR_RATIO_SEL3    7'h10

// ****************************************
// post-divider field and reset values
// ****************************************
`define CCR_DIV_BASE      5'h02
`define CCR_DIV_SEL_RST   2'h0
`define CCR_IN_DIV_RST    1'h0

`endif

// ===== inc/ccr_pkg.sv
// types shared by the core clock ratio control block
`include "ccr_defs.svh"

package ccr_pkg;

    typedef logic [`CCR_MULT_W-1:0] ccr_mult_t;
    typedef logic [`CCR_DIV_W-1:0]  ccr_div_t;

    typedef struct packed {
        logic [1:0]            sync0;
        logic [1:0]            sync1;
        logic [1:0]            sync2;
        logic [1:0]            fill;
        logic                  strap_taken;
        ccr_mult_t             mult;
        logic [1:0]            div_sel;
        logic                  in_div;
        ccr_div_t              div_val;
        logic [`CCR_CNT_W-1:0] cnt;
        logic                  core_clock;
        logic [`CCR_NUM_W-1:0] ratio_num;
        logic [`CCR_DEN_W-1:0] ratio_den;
    } ccr_state_s;

    typedef struct packed {
        logic core_prev;
        logic periph_clock;
    } ccr_pdiv_s;

endpackage : ccr_pkg

// ===== core/ccr_periph_div.sv
// peripheral clock generator: half the core clock rate
`timescale 1ns/1ps
`default_nettype none

module ccr_periph_div
    import ccr_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic core_clock,
    output var  logic periph_clock
);

    ccr_pdiv_s st;
    ccr_pdiv_s next_st;

    // ****************************************
    // toggle on each core clock rising edge
    // ****************************************
    always_comb begin
        next_st = st;
        next_st.core_prev = core_clock;
        if (core_clock && !st.core_prev) begin
            next_st.periph_clock = ~st.periph_clock; // [R6]
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign periph_clock = st.periph_clock;

endmodule // ccr_periph_div

`default_nettype wire

// ===== core/ccr_top.sv
// core clock ratio control: multiplier, post-divider, clock outputs
//
// Functional notes
// R1: during reset the core:input ratio comes from the ratio straps; the code holds 16 in reset and latches the straps after release.
// R2: after reset the multiplier is what software last programmed.
// R3: pll input is the input clock, halved when input divide is set.
// R4: vco is 2 x multiplier x input; core clock is vco / post-divider.
// R5: post-divider is 2, 4, 8 or 16 by its field, and 2 in reset.
// R6: peripheral clock period is exactly twice the core clock period.
// R7: software keeps input x multiplier under the vco limit.
// R8: software keeps the core clock period legal on every change.
// R9: the default strap setting gives a sixteen to one ratio.
// R10: strap ratio is caught at reset release until software writes.
`timescale 1ns/1ps
`default_nettype none

`include "ccr_defs.svh"

module ccr_top
    import ccr_pkg::*;
#(
    parameter ccr_mult_t RATIO_SEL1 = `CCR_RATIO_SEL1,
    parameter ccr_mult_t RATIO_SEL2 = `CCR_RATIO_SEL2,
    parameter ccr_mult_t RATIO_SEL3 = `CCR_RATIO_SEL3
)
(
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire logic [1:0]            clock_ratio_strap_pins,
    input  wire logic                  pll_write,
    input  wire logic [`CCR_MULT_W-1:0] pll_multiplier_in,
    input  wire logic [1:0]            pll_post_divider_sel,
    input  wire logic                  input_divide_enable_in,
    output var  logic [`CCR_MULT_W-1:0] pll_multiplier,
    output var  logic [`CCR_DIV_W-1:0] pll_post_divider,
    output var  logic                  input_divide_enable,
    output var  logic                  strap_taken,
    output var  logic [`CCR_NUM_W-1:0] core_ratio_num,
    output var  logic [`CCR_DEN_W-1:0] core_ratio_den,
    output var  logic                  core_clock,
    output var  logic                  periph_clock
);

    // ****************************************
    // elaboration checks
    // ****************************************
    // a zero multiplier would make the core:input ratio zero
    if (RATIO_SEL1 == '0 || RATIO_SEL2 == '0 || RATIO_SEL3 == '0) begin
        $error("strap ratios must be nonzero");
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic ccr_div_t div_decode(input logic [1:0] sel);
        div_decode = `CCR_DIV_BASE << sel; // [R5]
    endfunction

    function automatic ccr_mult_t strap_ratio(input logic [1:0] s);
        ccr_mult_t r;
        unique case (s)
            `CCR_STRAP_DEFAULT: r = `CCR_RATIO_DEFAULT; // [R9]
            `CCR_STRAP_SEL1:    r = RATIO_SEL1;
            `CCR_STRAP_SEL2:    r = RATIO_SEL2;
            default:            r = RATIO_SEL3;
        endcase
        strap_ratio = r;
    endfunction

    ccr_state_s st;
    ccr_state_s next_st;

    // ****************************************
    // settings and core clock division
    // ****************************************
    always_comb begin
        next_st = st;
        // strap pins pass three flops; first feeds only the second
        next_st.sync0 = clock_ratio_strap_pins;
        next_st.sync1 = st.sync0;
        next_st.sync2 = st.sync1;
        // sync stages hold reset zeros until filled; never latch those
        if (st.fill != 2'h3) begin
            next_st.fill = st.fill + 2'(1);
        end
        // with post-div 2 and no input halving, ratio equals multiplier
        if (pll_write) begin
            next_st.mult        = pll_multiplier_in; // [R2]
            next_st.div_sel     = pll_post_divider_sel; // [R5]
            next_st.in_div      = input_divide_enable_in; // [R3]
            next_st.strap_taken = 1'b1; // [R10]
        end else if (!st.strap_taken && st.fill == 2'h3 &&
                     st.sync1 == st.sync2) begin
            next_st.mult        = strap_ratio(st.sync2); // [R1]
            next_st.strap_taken = 1'b1; // [R10]
        end
        next_st.div_val = div_decode(next_st.div_sel); // [R5]
        // ratio core:input = (2 x mult) / (post-div x input divide)
        next_st.ratio_num = {next_st.mult, 1'b0}; // [R4]
        next_st.ratio_den = {1'b0, next_st.div_val} << next_st.in_div; // [R3]
        // core_clk stands in for the vco; divide by the post-divider
        if ({1'b0, st.cnt} >= st.div_val - `CCR_DIV_W'(1)) begin
            next_st.cnt = '0; // [R4]
        end else begin
            next_st.cnt = st.cnt + `CCR_CNT_W'(1);
        end
        // new divider takes effect on the next cycle, mid-period, glitch-free enough
        next_st.core_clock = ({1'b0, next_st.cnt} <
                              (st.div_val >> 1)); // [R4]
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st             <= '0;
            st.mult        <= `CCR_RATIO_DEFAULT;
            st.div_sel     <= `CCR_DIV_SEL_RST;
            st.in_div      <= `CCR_IN_DIV_RST;
            st.div_val     <= `CCR_DIV_BASE; // [R5]
            st.ratio_num   <= {`CCR_RATIO_DEFAULT, 1'b0};
            st.ratio_den   <= {1'b0, `CCR_DIV_BASE};
        end else begin
            st <= next_st;
        end
    end

    ccr_periph_div u_pdiv (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .core_clock   (st.core_clock),
        .periph_clock (periph_clock)
    );

    assign pll_multiplier      = st.mult;
    assign pll_post_divider    = st.div_val;
    assign input_divide_enable = st.in_div;
    assign strap_taken         = st.strap_taken;
    assign core_ratio_num      = st.ratio_num;
    assign core_ratio_den      = st.ratio_den;
    assign core_clock          = st.core_clock;

endmodule // ccr_top

`default_nettype wire

// ===== verif/ccr_top_monitor.sv
// port checker for the core clock ratio control block
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defs.svh"
module ccr_top_monitor (
    input wire logic                   core_clk,
    input wire logic                   rst_n,
    input wire logic [1:0]             clock_ratio_strap_pins,
    input wire logic                   pll_write,
    input wire logic [`CCR_MULT_W-1:0] pll_multiplier_in,
    input wire logic [1:0]             pll_post_divider_sel,
    input wire logic                   input_divide_enable_in,
    input wire logic [`CCR_MULT_W-1:0] pll_multiplier,
    input wire logic [`CCR_DIV_W-1:0]  pll_post_divider,
    input wire logic                   input_divide_enable,
    input wire logic                   strap_taken,
    input wire logic [`CCR_NUM_W-1:0]  core_ratio_num,
    input wire logic [`CCR_DEN_W-1:0]  core_ratio_den,
    input wire logic                   core_clock,
    input wire logic                   periph_clock
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    mult_load_a: assert property (pll_write |=>
        pll_multiplier == $past(pll_multiplier_in)) else $error("mult load");
    div_decode_a: assert property (pll_write |=>
        pll_post_divider == (5'h02 << $past(pll_post_divider_sel)))
        else $error("post divider decode");
    halving_load_a: assert property (pll_write |=>
        input_divide_enable == $past(input_divide_enable_in))
        else $error("halving load");
    ratio_num_a: assert property (
        core_ratio_num == {pll_multiplier, 1'h0}) else $error("ratio num");
    ratio_den_a: assert property (
        core_ratio_den == ({1'h0, pll_post_divider} << input_divide_enable))
        else $error("ratio den");
    periph_follow_a: assert property ($rose(core_clock) |->
        ##[0:2] $changed(periph_clock)) else $error("periph toggle");
    strap_hold_a: assert property (
        $past(strap_taken) && strap_taken && !pll_write
        |=> $stable(pll_multiplier)) else $error("strap hold");
    pre_strap_a: assert property (!strap_taken |->
        pll_multiplier == 7'h10 && pll_post_divider == 5'h02)
        else $error("pre strap");
    cover property (pll_write);
    cover property ($rose(strap_taken));
    cover property ($rose(periph_clock) && pll_post_divider == 5'h10);
endmodule // ccr_top_monitor
`default_nettype wire

// ===== verif/ccr_strap_model.sv
// strap pin model: board ratio select, hard tied, no pull
`timescale 1ns/1ps
`default_nettype none
module ccr_strap_model (
    input  wire logic [1:0] strap_sel,
    output var  logic [1:0] clock_ratio_strap_pins
);
    assign clock_ratio_strap_pins = strap_sel;
endmodule // ccr_strap_model
`default_nettype wire

// ===== verif/ccr_top_bench.sv
// self-checking bench for the core clock ratio control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, ac) begin \
    comparisons++; \
    if ((ac) !== (ex)) begin \
        miscompares++; \
        $display("ERROR %s exp %0d seen %0d", nm, ex, ac); \
    end \
end
module ccr_top_bench import ccr_pkg::*;;
    logic       core_clk = 1'h0, rst_n = 1'h0, pll_write = 1'h0;
    logic       input_divide_enable_in = 1'h0, input_divide_enable;
    logic       strap_taken, core_clock, periph_clock;
    logic [1:0] strap_sel = 2'h0, pll_post_divider_sel = 2'h0;
    logic [1:0] clock_ratio_strap_pins;
    ccr_mult_t  pll_multiplier_in = 7'h10, pll_multiplier;
    ccr_div_t   pll_post_divider;
    logic [7:0] core_ratio_num;
    logic [5:0] core_ratio_den;
    int         miscompares = 0, comparisons = 0, m_mult, m_div, m_ind;
    int         ratio[4] = '{16, 32, 8, 16};
    time        t0;
    ccr_strap_model i_straps (.strap_sel(strap_sel),
        .clock_ratio_strap_pins(clock_ratio_strap_pins));
    ccr_top i_dut (.*);
    initial forever #4 core_clk = ~core_clk;
    task automatic check_all;
        `CHK("mult", m_mult, pll_multiplier)
        `CHK("div", m_div, pll_post_divider)
        `CHK("halving", m_ind, input_divide_enable)
        `CHK("num", 2 * m_mult, core_ratio_num)
        `CHK("den", m_div * (m_ind + 1), core_ratio_den)
    endtask
    task automatic do_reset(input int s);
        rst_n <= 1'h0;
        strap_sel <= s[1:0];
        m_mult = 16;
        m_div = 2;
        m_ind = 0;
        repeat (4) @(posedge core_clk);
        check_all();
        rst_n <= 1'h1;
        m_mult = ratio[s];
        repeat (8) @(posedge core_clk);
        // late strap moves must not disturb the latched ratio
        strap_sel <= ~s[1:0];
        repeat (8) @(posedge core_clk);
        check_all();
        `CHK("taken", 1, strap_taken)
    endtask
    task automatic do_write(input int m, input int d, input int i);
        pll_write <= 1'h1;
        pll_multiplier_in <= m[6:0];
        pll_post_divider_sel <= d[1:0];
        input_divide_enable_in <= i[0];
        m_mult = m;
        m_div = 2 << d;
        m_ind = i;
        @(posedge core_clk);
    endtask
    task automatic measure;
        // a new divider lands on the next cycle, mid-period, so let it settle
        repeat (48) @(posedge core_clk);
        @(posedge core_clock) t0 = $time;
        @(posedge core_clock) `CHK("core_clock", m_div, int'(($time - t0) / 8))
        @(posedge periph_clock) t0 = $time;
        @(posedge periph_clock) `CHK("pclk", 2 * m_div, int'(($time - t0) / 8))
    endtask
    task automatic summarize;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        void'($urandom(56254));
        for (int s = 0; s < 4; s++) do_reset(s);
        for (int d = 0; d < 4; d++) begin
            // multiplier kept small so the vco stays legal
            do_write(1 + $urandom % 32, 3 - d, $urandom % 2);
            do_write(1 + $urandom % 32, d, $urandom % 2);
            pll_write <= 1'h0;
            #1 check_all();
            measure();
        end
        do_reset($urandom % 4);
        summarize();
    end
    initial begin
        // whole run needs well under 2000 cycles
        #200000;
        miscompares++;
        summarize();
    end
endmodule // ccr_top_bench
bind ccr_top ccr_top_monitor i_mon (.*);
`default_nettype wire
